// ===== rtl/ftc_channel.v
// one tachometer channel: pin sync, divisor prescaler, saturating counter, latch
`default_nettype none
`include "ftc_consts.vh"
module ftc_channel (
   input  wire       pclk,
   input  wire       presetn,
   input  wire       tick,
   input  wire [1:0] div_sel,
   input  wire       double_rate,
   input  wire       tach_pin,
   output reg  [7:0] count
);
   reg       sync_a;
   reg       sync_b;
   reg       prev;
   reg [2:0] pre;
   reg [7:0] run;
   wire      rise;
   wire      cnt_en;
   wire [8:0] sum;
   wire [2:0] limit;
   wire [7:0] step;
   wire       first_en;

   // divisor code to last prescaler value (divisor minus one)
   function [2:0] div_limit;
      input [1:0] sel;
      begin
         case (sel)
            `FTC_DIV_1: div_limit = 3'h0;
            `FTC_DIV_2: div_limit = 3'h1;
            `FTC_DIV_4: div_limit = 3'h3;
            default:    div_limit = 3'h7;
         endcase
      end
   endfunction

   assign limit  = div_limit(div_sel);
   assign rise   = sync_b & ~prev;
   assign cnt_en = tick & (pre >= limit);
   // doubling advances two counts per divided tick
   assign step     = double_rate ? 8'h02 : 8'h01;
   // a tick in the edge cycle opens the new period, so no tick is lost at the
   // boundary; the tick phase against the pin can still move the result by one
   assign first_en = tick & (limit == 3'h0);
   assign sum      = {1'b0, run} + {1'b0, step};

   // two-flop synchroniser, edge detect reads only the second stage
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         prev   <= 1'b0;
      end else begin
         sync_a <= tach_pin;
         sync_b <= sync_a;
         prev   <= sync_b;
      end
   end

   // prescaler restarts with each pulse; >= copes with a divisor change mid-count
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre <= 3'h0;
      end else if (rise) begin
         if (tick & (limit != 3'h0)) begin
            pre <= 3'h1;
         end else begin
            pre <= 3'h0;
         end
      end else if (tick) begin
         if (pre >= limit) begin
            pre <= 3'h0;
         end else begin
            pre <= pre + 3'h1;
         end
      end
   end

   // period counter; latch the finished pulse on each rising edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run   <= `FTC_COUNT_RESET;
         count <= `FTC_COUNT_RESET;
      end else if (rise) begin
         count <= run;
         run   <= first_en ? step : `FTC_COUNT_RESET;
      end else if (cnt_en) begin
         if (sum[8]) begin
            run <= `FTC_COUNT_MAX;
         end else begin
            run <= sum[7:0];
         end
      end
   end
endmodule // ftc_channel
`default_nettype wire

// ===== rtl/ftc_consts.vh
// constants for the fan tachometer counter
`ifndef FTC_CONSTS_VH
`define FTC_CONSTS_VH
// register indices; byte address is four times the index
`define FTC_IDX_CONFIG       8'h58
`define FTC_IDX_FIRST_COUNT  8'h59
`define FTC_IDX_SECOND_COUNT 8'h5A
// configuration fields
`define FTC_CFG_SPEED_SEL    1
`define FTC_CFG_MULT         3
`define FTC_CFG_FIRST_DIV_LO 4
`define FTC_CFG_FIRST_DIV_HI 5
`define FTC_CFG_SECOND_DIV_LO 6
`define FTC_CFG_SECOND_DIV_HI 7
// reset values: both divisor fields select 2, multiplier off
`define FTC_CFG_RESET        8'h50
`define FTC_COUNT_RESET      8'h00
`define FTC_COUNT_MAX        8'hFF
// divisor codes
`define FTC_DIV_1            2'h0
`define FTC_DIV_2            2'h1
`define FTC_DIV_4            2'h2
`define FTC_DIV_8            2'h3
// base internal count clock: pclk cycles per count tick
`define FTC_BASE_DIV         50
`endif

// ===== rtl/ftc_top.v
// fan tachometer counter with APB register access
//
// Summary of operation
// - With the multiplier bit set, the second fan's count rate is doubled; clear, no doubling.
// - The first fan count clock is divided by 1, 2, 4 or 8 per config bits 5:4.
// - The second fan count clock is divided by 1, 2, 4 or 8 per config bits 7:6.
// - After reset both divisor fields select a divisor of 2.
// - The first fan's result is an 8-bit count readable by software.
// - The counter advances once per divided count tick during each fan pulse period.
// - At the end of each pulse the final count is latched, so the register holds the last pulse.
`default_nettype none
`include "ftc_consts.vh"

// register map (byte address is four times the register index)
//   config word        read/write, reset value selects divisor 2 for both fans
//     bit 1            speed select, stored only; it has no effect on counting here
//     bit 3            second fan rate doubling
//     bits 5:4         first fan divisor code: 0 -> 1, 1 -> 2, 2 -> 4, 3 -> 8
//     bits 7:6         second fan divisor code, same encoding
//     other bits       stored and read back
//   first count word   read only, the finished count of the last first fan pulse
//   second count word  read only, the same for the second fan
//   any other address  reads as zero with an error response
//
// bus timing
//   zero wait states: ready is tied high
//   read data is captured at the end of the setup cycle and held until the next
//   read setup, so it is already stable when the access cycle samples it
//   a write lands at the end of the access cycle
//   writes to the count words and misaligned accesses are refused with an error
//
// count timing
//   a base tick fires once every BASE_DIV clocks; each fan divides it further
//   the tach pins are resynchronised, so a pin edge is seen three clocks late
//   a rising pin edge ends the period: the running count is latched and restarts
//   the running count stops at its maximum rather than wrapping
//   a changed divisor acts at the next tick; the >= compare never strands it
//   the first result after reset or after a divisor change covers a partial
//   period, so software should let two pulses pass before it trusts a reading
//
// reset
//   the asynchronous reset doubles as the standby supply power-on reset
//   it clears both counts, restores the configuration default and idles the bus
//   assertion may come at any time; release should be clean against the clock
//
// limitation: the period is measured between rising edges only, so duty cycle
// does not matter, but pulses shorter than two clocks high or low may be missed
module ftc_top #(
   parameter BASE_DIV = `FTC_BASE_DIV
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        first_fan_tach,
   input  wire        second_fan_tach
);
   // the block serves exactly two fans; the channel wiring below is sized by it
   localparam NUM_FANS = 2;

   reg  [7:0]            config_reg;
   reg  [7:0]            next_config;
   reg  [31:0]           next_prdata;
   reg  [15:0]           base_cnt;
   reg  [15:0]           next_base_cnt;
   reg                   tick;
   reg                   next_tick;
   wire [NUM_FANS-1:0]   tach_in;
   wire [NUM_FANS-1:0]   double_in;
   wire [2*NUM_FANS-1:0] div_in;
   wire [8*NUM_FANS-1:0] count_all;
   wire [7:0]            first_count;
   wire [7:0]            second_count;
   wire                  hit_cfg;
   wire                  hit_first;
   wire                  hit_second;
   wire                  mapped;
   wire                  setup;
   wire                  access;
   wire                  rd_setup;
   wire                  wr_cfg;
   wire                  refused;

   // true when an address is the aligned word of the given register index
   function reg_hit;
      input [11:0] addr;
      input [7:0]  idx;
      begin
         reg_hit = (addr[1:0] == 2'h0) && (addr[11:2] == {2'h0, idx});
      end
   endfunction

   // an 8-bit register as a bus word, upper bits zero
   function [31:0] pad_word;
      input [7:0] value;
      begin
         pad_word = {24'h000000, value};
      end
   endfunction

   // bus phase and address decode; a misaligned address matches no register
   assign setup      = psel & ~penable;
   assign access     = psel & penable;
   assign rd_setup   = setup & ~pwrite;
   assign hit_cfg    = reg_hit(paddr, `FTC_IDX_CONFIG);
   assign hit_first  = reg_hit(paddr, `FTC_IDX_FIRST_COUNT);
   assign hit_second = reg_hit(paddr, `FTC_IDX_SECOND_COUNT);
   assign mapped     = hit_cfg | hit_first | hit_second;
   assign wr_cfg     = access & pwrite & hit_cfg;
   // writes to the count words are refused like unmapped addresses
   assign refused    = ~mapped | (pwrite & ~hit_cfg);

   // zero wait states; read data is captured in the setup cycle
   assign pready  = 1'b1;
   // the error flag stands only in the access cycle
   assign pslverr = access & refused;

   // base tick divider; the tick is registered so every channel sees it in the
   // same cycle, at the cost of one clock of latency that the count never notices
   always @* begin
      if (base_cnt >= BASE_DIV[15:0] - 16'h0001) begin
         next_base_cnt = 16'h0000;
         next_tick     = 1'b1;
      end else begin
         next_base_cnt = base_cnt + 16'h0001;
         next_tick     = 1'b0;
      end
   end

   // base tick flops, cleared so the first tick comes a full span after reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         base_cnt <= 16'h0000;
         tick     <= 1'b0;
      end else begin
         base_cnt <= next_base_cnt;
         tick     <= next_tick;
      end
   end

   // next configuration word; a write lands at the end of the access cycle
   always @* begin
      next_config = config_reg;
      if (wr_cfg) begin
         next_config = pwdata[7:0];
      end
   end

   // configuration register; reset selects divisor 2 on both fans
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_reg <= `FTC_CFG_RESET;
      end else begin
         config_reg <= next_config;
      end
   end

   // read select; holding the word outside read setups keeps it stable
   // for the whole access cycle, and unmapped reads return zero
   always @* begin
      next_prdata = prdata;
      if (rd_setup) begin
         if (hit_cfg) begin
            next_prdata = pad_word(config_reg);
         end else if (hit_first) begin
            next_prdata = pad_word(first_count);
         end else if (hit_second) begin
            next_prdata = pad_word(second_count);
         end else begin
            next_prdata = 32'h00000000;
         end
      end
   end

   // read data flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else begin
         prdata <= next_prdata;
      end
   end

   // per-fan wiring; only the second fan can be doubled
   assign tach_in      = {second_fan_tach, first_fan_tach};
   assign div_in       = {config_reg[`FTC_CFG_SECOND_DIV_HI:`FTC_CFG_SECOND_DIV_LO],
                          config_reg[`FTC_CFG_FIRST_DIV_HI:`FTC_CFG_FIRST_DIV_LO]};
   assign double_in    = {config_reg[`FTC_CFG_MULT], 1'b0};
   assign first_count  = count_all[7:0];
   assign second_count = count_all[15:8];

   // one measuring channel per fan, all sharing the base tick
   genvar fan;
   generate
      for (fan = 0; fan < NUM_FANS; fan = fan + 1) begin : g_fan
         ftc_channel ftc_channel_inst (
            .pclk        (pclk),
            .presetn     (presetn),
            .tick        (tick),
            .div_sel     (div_in[2*fan+1:2*fan]),
            .double_rate (double_in[fan]),
            .tach_pin    (tach_in[fan]),
            .count       (count_all[8*fan+7:8*fan])
         );
      end
   endgenerate
endmodule // ftc_top
`default_nettype wire

// ===== verification/ftc_fan_model.sv
// two fan tachometer pulse sources
`default_nettype none
module ftc_fan_model (
   input  wire logic       pclk,
   input  var  int         period [2],
   output var  logic [1:0] tach
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt [2] = '{0, 0};
   initial tach = 2'h0;
   // half-period high train; period 0 parks the pin low
   always @(posedge pclk) begin
      for (int i = 0; i < 2; i++) begin
         cnt[i] <= (cnt[i] + 1 >= period[i]) ? 0 : cnt[i] + 1;
         tach[i] <= (period[i] != 0) && (cnt[i] < period[i] / 2);
      end
   end
endmodule // ftc_fan_model
`default_nettype wire

// ===== verification/ftc_top_sva.sv
// bus-side assertions for the fan tachometer counter
`default_nettype none
module ftc_top_sva #(parameter BASE_DIV = 50) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc = psel & penable;
   sequence rd_setup;
      psel && !penable && !pwrite;
   endsequence
   a_no_wait: assert property (acc |-> pready) else $error("wait");
   a_err_idle: assert property (!acc |-> !pslverr) else $error("idle err");
   a_count_ro: assert property (acc && pwrite && paddr == 12'h164 |-> pslverr)
      else $error("ro write");
   a_cfg_ok: assert property (acc && paddr == 12'h160 |-> !pslverr) else $error("cfg");
   a_upper_zero: assert property (prdata[31:8] == 24'h0) else $error("upper");
   a_misalign: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr) else $error("align");
   a_rd_unmapped: assert property (rd_setup ##0 paddr == 12'h100 ##1 acc
      |-> prdata == 32'h0 && pslverr) else $error("unmapped");
   a_rd_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("hold");
endmodule // ftc_top_sva
bind ftc_top ftc_top_sva #(.BASE_DIV(BASE_DIV)) ftc_top_sva_inst (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ===== verification/tb_fan_tachometer_counter.sv
// self-checking bench for the fan tachometer counter
`default_nettype none
module tb_fan_tachometer_counter;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, er;
   logic [1:0]  tach;
   int          per [2] = '{0, 0};
   int          mismatches = 0, checks = 0;
   always #10 pclk = ~pclk;
   ftc_top #(.BASE_DIV(2)) ftc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .first_fan_tach(tach[0]), .second_fan_tach(tach[1]));
   ftc_fan_model ftc_fan_model_inst (.pclk(pclk), .period(per), .tach(tach));
   task automatic check(input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // tick phase may land a count one either way
   function automatic logic [31:0] near(input logic [31:0] s, e);
      near = (s + 1 >= e && s <= e + 1) ? e : s;
   endfunction
   task automatic meas(input logic [7:0] cfg, input int a, b, input logic [31:0] e1, e2);
      per[0] <= a;
      per[1] <= b;
      apb(1'b1, 12'h160, {24'h0, cfg});
      repeat (3 * a + 20) @(posedge pclk);
      apb(1'b0, 12'h164, 32'h0);
      check(near(rd, e1), e1);
      apb(1'b0, 12'h168, 32'h0);
      check(near(rd, e2), e2);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h160, 32'h0);
      check(rd, 32'h50);
      apb(1'b0, 12'h164, 32'h0);
      check(rd, 32'h0);
      $display("test reset done");
      for (int d = 0; d < 4; d++) meas({d[1:0], d[1:0], 4'h0}, 64, 64, 32 >> d, 32 >> d);
      meas(8'h58, 64, 64, 16, 32);
      meas(8'h00, 1200, 64, 32'hFF, 32);
      $display("test rate done");
      apb(1'b1, 12'h164, 32'h5A);
      check(er, 1'b1);
      apb(1'b0, 12'h164, 32'h0);
      check(rd, 32'hFF);
      apb(1'b0, 12'h100, 32'h0);
      check(er, 1'b1);
      apb(1'b0, 12'h161, 32'h0);
      check(er, 1'b1);
      $display("test bus done");
      end_of_test;
   end
   // watchdog well beyond the expected run
   initial begin
      #400000;
      mismatches++;
      end_of_test;
   end
endmodule // tb_fan_tachometer_counter
`default_nettype wire
